// [hw/adc_control_register_file.sv]
// APB register file of the converter: control, reference, flags, result, thresholds
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps

module adc_control_register_file #(
   parameter int SYNC_CYCLES = adc_regs_pkg::SYNC_CYCLES_DEFAULT
) (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [7:0]                        paddr,
   input  wire logic [31:0]                       pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic      [31:0]                       prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic                              peripheral_access_controller,
   input  wire logic                              result_done,
   input  wire logic [15:0]                       result_data,
   input  wire logic                              window_hit,
   input  wire logic                              overrun_hit,
   output logic                                   keep_running_asleep,
   output logic                                   converter_enabled,
   output logic                                   ref_buffer_compensation,
   output logic      [3:0]                        reference_choice,
   output adc_regs_pkg::reference_source_type     reference_source,
   output logic      [15:0]                       window_lower,
   output logic      [15:0]                       window_upper,
   output logic      [adc_regs_pkg::CORR_WIDTH-1:0] gain_value,
   output logic      [adc_regs_pkg::CORR_WIDTH-1:0] offset_value,
   output logic                                   debug_run,
   output logic      [adc_regs_pkg::FLAG_WIDTH-1:0] irq_enable_mask,
   output logic      [adc_regs_pkg::FLAG_WIDTH-1:0] irq_flag_bits
);
   import adc_regs_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction

   function automatic reference_source_type decode_ref(input logic [3:0] code);
      case (code)
         4'h0:    decode_ref = ref_internal_one_volt;
         4'h1:    decode_ref = ref_supply_fraction_a;
         4'h2:    decode_ref = ref_supply_fraction_b;
         4'h3:    decode_ref = ref_external_a;
         4'h4:    decode_ref = ref_external_b;
         default: decode_ref = ref_reserved;
      endcase
   endfunction

   function automatic logic addr_is(input logic [7:0] a, input logic [5:0] idx);
      addr_is = (a == {idx, 2'b00});
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic                  sreset_q;
   logic                  enable_q;
   logic                  stdby_q;
   logic                  conv_en_q;
   logic                  busy_q;
   logic [7:0]            cnt_q;
   logic                  comp_q;
   logic [3:0]            choice_q;
   logic [FLAG_WIDTH-1:0] ien_q;
   logic [FLAG_WIDTH-1:0] flags_q;
   logic [FLAG_WIDTH-1:0] flags_d;
   logic [15:0]           result_q;
   logic [15:0]           lower_q;
   logic [15:0]           upper_q;
   logic [15:0]           gain_q;
   logic [15:0]           offset_q;
   logic                  dbg_q;
   logic [31:0]           prdata_q;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire hit_main   = addr_is(paddr, IDX_MAIN);
   wire hit_ref    = addr_is(paddr, IDX_REF);
   wire hit_ienclr = addr_is(paddr, IDX_IENCLR);
   wire hit_ienset = addr_is(paddr, IDX_IENSET);
   wire hit_flags  = addr_is(paddr, IDX_FLAGS);
   wire hit_status = addr_is(paddr, IDX_STATUS);
   wire hit_result = addr_is(paddr, IDX_RESULT);
   wire hit_lower  = addr_is(paddr, IDX_LOWER);
   wire hit_upper  = addr_is(paddr, IDX_UPPER);
   wire hit_gain   = addr_is(paddr, IDX_GAIN);
   wire hit_offset = addr_is(paddr, IDX_OFFSET);
   wire hit_debug  = addr_is(paddr, IDX_DEBUG);
   wire mapped     = hit_main | hit_ref | hit_ienclr | hit_ienset | hit_flags | hit_status
                   | hit_result | hit_lower | hit_upper | hit_gain | hit_offset | hit_debug;

   wire access     = psel & penable;
   // Synchronized writes stall the bus while an earlier one is still crossing
   wire sync_reg   = hit_main | hit_lower | hit_upper;
   wire stall      = busy_q & pwrite & sync_reg;
   wire wr_fire    = access & pwrite & ~stall & mapped;
   wire prot_ok    = ~peripheral_access_controller;
   wire active     = enable_q | conv_en_q;
   wire ep_ok      = ~active;
   wire wr_main    = wr_fire & hit_main & prot_ok & pstrb[0];
   wire sreset_req = wr_main & pwdata[MAIN_SRESET_BIT];
   wire ctrl_upd   = wr_main & ~pwdata[MAIN_SRESET_BIT];
   wire wr_ref     = wr_fire & hit_ref & prot_ok & pstrb[0];
   wire wr_lower   = wr_fire & hit_lower & prot_ok;
   wire wr_upper   = wr_fire & hit_upper & prot_ok;
   wire wr_gain    = wr_fire & hit_gain & prot_ok & ep_ok;
   wire wr_offset  = wr_fire & hit_offset & prot_ok & ep_ok;
   wire wr_debug   = wr_fire & hit_debug & prot_ok & pstrb[0];
   wire wr_win_any = (wr_lower | wr_upper) & (pstrb[0] | pstrb[1]);
   wire sync_start = wr_main | wr_win_any;
   wire sync_done  = busy_q & (cnt_q == 8'h01);
   wire soft_clr   = sync_done & sreset_q;
   wire [FLAG_WIDTH-1:0] wr_bits = pwdata[FLAG_WIDTH-1:0];
   wire [FLAG_WIDTH-1:0] ien_clr = (wr_fire & hit_ienclr & pstrb[0]) ? wr_bits : '0;
   wire [FLAG_WIDTH-1:0] ien_set = (wr_fire & hit_ienset & pstrb[0]) ? wr_bits : '0;
   wire [FLAG_WIDTH-1:0] flg_clr = (wr_fire & hit_flags & pstrb[0]) ? wr_bits : '0;
   wire [FLAG_WIDTH-1:0] flg_set = {sync_done, window_hit, overrun_hit, result_done};

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   wire [7:0]  main_rd  = {5'h00, stdby_q, enable_q, sreset_q};
   wire [7:0]  ref_rd   = {comp_q, 3'h0, choice_q};
   wire [7:0]  stat_rd  = {busy_q, 7'h00};
   wire [31:0] rd_word  =
        hit_main                 ? {24'h000000, main_rd} :
        hit_ref                  ? {24'h000000, ref_rd} :
        (hit_ienclr | hit_ienset) ? {28'h0000000, ien_q} :
        hit_flags                ? {28'h0000000, flags_q} :
        hit_status               ? {24'h000000, stat_rd} :
        hit_result               ? {16'h0000, result_q} :
        hit_lower                ? {16'h0000, lower_q} :
        hit_upper                ? {16'h0000, upper_q} :
        hit_gain                 ? {16'h0000, gain_q} :
        hit_offset               ? {16'h0000, offset_q} :
        hit_debug                ? {31'h00000000, dbg_q} : 32'h00000000;

   assign pready  = ~stall;
   assign pslverr = access & ~mapped;
   assign prdata  = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (psel & ~pwrite) begin
         prdata_q <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // Main control and synchronization
   // ------------------------------------------------------------
   // Busy is held for a fixed count standing in for the converter clock crossing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else if (sync_start) begin
         busy_q <= 1'b1;
         cnt_q  <= 8'(SYNC_CYCLES);
      end else if (sync_done) begin
         busy_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else if (busy_q) begin
         cnt_q  <= cnt_q - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sreset_q  <= 1'b0;
         enable_q  <= 1'b0;
         stdby_q   <= 1'b0;
         conv_en_q <= 1'b0;
      end else begin
         if (soft_clr) begin
            sreset_q  <= 1'b0;
            enable_q  <= 1'b0;
            stdby_q   <= 1'b0;
            conv_en_q <= 1'b0;
         end else begin
            if (sreset_req) begin
               sreset_q <= 1'b1;
            end else if (ctrl_upd) begin
               enable_q <= pwdata[MAIN_ENABLE_BIT];
               stdby_q  <= pwdata[MAIN_STDBY_BIT];
            end
            if (sync_done) begin
               conv_en_q <= enable_q;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Reference, thresholds, corrections, debug
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comp_q   <= 1'b0;
         choice_q <= 4'h0;
         lower_q  <= RESET_HALF;
         upper_q  <= RESET_HALF;
         gain_q   <= RESET_HALF;
         offset_q <= RESET_HALF;
         result_q <= RESET_HALF;
      end else if (soft_clr) begin
         comp_q   <= 1'b0;
         choice_q <= 4'h0;
         lower_q  <= RESET_HALF;
         upper_q  <= RESET_HALF;
         gain_q   <= RESET_HALF;
         offset_q <= RESET_HALF;
         result_q <= RESET_HALF;
      end else begin
         if (wr_ref) begin
            comp_q   <= pwdata[REF_COMP_BIT];
            choice_q <= pwdata[REF_CHOICE_MSB:0];
         end
         if (wr_lower) lower_q <= merge16(lower_q, pwdata, pstrb);
         if (wr_upper) upper_q <= merge16(upper_q, pwdata, pstrb);
         if (wr_gain) gain_q <= merge16(gain_q, pwdata, pstrb) & 16'h0fff;
         if (wr_offset) offset_q <= merge16(offset_q, pwdata, pstrb) & 16'h0fff;
         if (result_done) result_q <= result_data;
      end
   end

   // Debug control survives a soft reset on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_q <= 1'b0;
      end else if (wr_debug) begin
         dbg_q <= pwdata[DEBUG_RUN_BIT];
      end
   end

   // ------------------------------------------------------------
   // Interrupt enables and flags
   // ------------------------------------------------------------
   // A new event in the clearing cycle wins over the clear
   assign flags_d = soft_clr ? flg_set : ((flags_q & ~flg_clr) | flg_set);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_q   <= '0;
         flags_q <= '0;
      end else begin
         ien_q   <= soft_clr ? '0 : ((ien_q & ~ien_clr) | ien_set);
         flags_q <= flags_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign keep_running_asleep     = stdby_q;
   assign converter_enabled       = conv_en_q;
   assign ref_buffer_compensation = comp_q;
   assign reference_choice        = choice_q;
   assign reference_source        = decode_ref(choice_q);
   assign window_lower            = lower_q;
   assign window_upper            = upper_q;
   assign gain_value              = gain_q[CORR_WIDTH-1:0];
   assign offset_value            = offset_q[CORR_WIDTH-1:0];
   assign debug_run               = dbg_q;
   assign irq_enable_mask         = ien_q;
   assign irq_flag_bits           = flags_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_ctrl_readback: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_upd & ~soft_clr |=> enable_q == $past(pwdata[MAIN_ENABLE_BIT])
                              && stdby_q == $past(pwdata[MAIN_STDBY_BIT]))
      else $error("control bits did not read back");

   a_busy_window: assert property (@(posedge pclk) disable iff (!presetn)
      sync_start |=> busy_q ##[1:1000] !busy_q)
      else $error("sync busy not set or never cleared");

   a_enable_apply: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(busy_q) && !$past(sreset_q) |-> conv_en_q == enable_q)
      else $error("enable not applied when busy cleared");

   a_sreset_drop: assert property (@(posedge pclk) disable iff (!presetn)
      sreset_req |=> sreset_q && $stable(enable_q) && $stable(stdby_q))
      else $error("soft reset write changed other bits");

   a_sreset_end: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(sreset_q) |-> !busy_q && !enable_q && !conv_en_q && choice_q == 4'h0
                         && gain_q == RESET_HALF && lower_q == RESET_HALF)
      else $error("soft reset end state wrong");

   a_sreset_busy: assert property (@(posedge pclk) disable iff (!presetn)
      sreset_q |-> busy_q)
      else $error("soft reset bit set without sync busy");

   a_zero_noop: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_upd |=> !sreset_q)
      else $error("zero write started a soft reset");

   a_wp_hold: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire & hit_ref & peripheral_access_controller & ~soft_clr |=> $stable(ref_rd))
      else $error("protected register changed");

   a_ep_hold: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire & hit_gain & active & ~soft_clr |=> $stable(gain_q))
      else $error("enable-protected register changed");

   // Offset shares the enable protection of gain
   a_offset_hold: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire & hit_offset & active & ~soft_clr |=> $stable(offset_q))
      else $error("enable-protected offset changed");

   a_lane_keep: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire & hit_lower & ~pstrb[1] & ~soft_clr |=> $stable(lower_q[15:8]))
      else $error("unstrobed byte lane changed");

   a_flag_setwins: assert property (@(posedge pclk) disable iff (!presetn)
      overrun_hit |=> flags_q[FLAG_OVRUN_BIT])
      else $error("flag event lost");

   a_ref_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (choice_q > REF_CODE_MAX) |-> reference_source == ref_reserved)
      else $error("reserved reference code not flagged");

   a_ref_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_ref & ~soft_clr |=> comp_q == $past(pwdata[REF_COMP_BIT])
                             && choice_q == $past(pwdata[REF_CHOICE_MSB:0]))
      else $error("reference control write lost");

   // An event in the same cycle wins, so only quiet bits must drop
   a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (flg_clr != '0) & ~soft_clr |=> (flags_q & $past(flg_clr) & ~$past(flg_set)) == '0)
      else $error("flag not cleared by a one");

   a_ien_set: assert property (@(posedge pclk) disable iff (!presetn)
      (ien_set != '0) & ~soft_clr |=> (ien_q & $past(ien_set)) == $past(ien_set))
      else $error("interrupt enable not set by a one");

   a_debug_keep: assert property (@(posedge pclk) disable iff (!presetn)
      soft_clr & ~wr_debug |=> $stable(dbg_q))
      else $error("debug control lost in soft reset");

   c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn) $fell(sreset_q));
   c_reset_req:  cover property (@(posedge pclk) disable iff (!presetn) sreset_req);
   c_enable_on:  cover property (@(posedge pclk) disable iff (!presetn) $rose(conv_en_q));
   c_stall:      cover property (@(posedge pclk) disable iff (!presetn) access & stall);
   c_bad_addr:   cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // adc_control_register_file

// [hw/adc_regs_pkg.sv]
// Register map, field positions and timing constants of the converter register file
package adc_regs_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_MAIN   = 6'h00;
   localparam logic [5:0] IDX_REF    = 6'h01;
   localparam logic [5:0] IDX_IENCLR = 6'h16;
   localparam logic [5:0] IDX_IENSET = 6'h17;
   localparam logic [5:0] IDX_FLAGS  = 6'h18;
   localparam logic [5:0] IDX_STATUS = 6'h19;
   localparam logic [5:0] IDX_RESULT = 6'h1a;
   localparam logic [5:0] IDX_LOWER  = 6'h1c;
   localparam logic [5:0] IDX_UPPER  = 6'h20;
   localparam logic [5:0] IDX_GAIN   = 6'h24;
   localparam logic [5:0] IDX_OFFSET = 6'h26;
   localparam logic [5:0] IDX_DEBUG  = 6'h2a;
   // Field positions
   localparam int MAIN_SRESET_BIT = 0;
   localparam int MAIN_ENABLE_BIT = 1;
   localparam int MAIN_STDBY_BIT  = 2;
   localparam int REF_COMP_BIT    = 7;
   localparam int REF_CHOICE_MSB  = 3;
   localparam int FLAG_RESULT_BIT = 0;
   localparam int FLAG_OVRUN_BIT  = 1;
   localparam int FLAG_WINDOW_BIT = 2;
   localparam int FLAG_SYNC_BIT   = 3;
   localparam int FLAG_WIDTH      = 4;
   localparam int STATUS_BUSY_BIT = 7;
   localparam int CORR_WIDTH      = 12;
   localparam int DEBUG_RUN_BIT   = 0;
   // Reset values
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_HALF = 16'h0000;
   // Highest defined reference code
   localparam logic [3:0]  REF_CODE_MAX = 4'h4;
   // Bus clock cycles for a write to reach the converter domain
   localparam int SYNC_CYCLES_DEFAULT = 4;
   typedef enum logic [2:0] {
      ref_internal_one_volt,
      ref_supply_fraction_a,
      ref_supply_fraction_b,
      ref_external_a,
      ref_external_b,
      ref_reserved
   } reference_source_type;
endpackage

// [bench/adc_control_register_file_test.sv]
// Self-checking APB bench for the converter register file
`timescale 1ns/10ps
module adc_control_register_file_test;
   import adc_regs_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   // Longer sync than default so busy is still visible to a read
   localparam int SYNC = 8;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0;
   logic [3:0]           pstrb = 4'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 peripheral_access_controller = 1'b0;
   logic                 result_done = 1'b0;
   logic [15:0]          result_data = 16'h0000;
   logic                 window_hit = 1'b0;
   logic                 overrun_hit = 1'b0;
   logic                 keep_running_asleep;
   logic                 converter_enabled;
   logic                 ref_buffer_compensation;
   logic [3:0]           reference_choice;
   reference_source_type reference_source;
   logic [15:0]          window_lower;
   logic [15:0]          window_upper;
   logic [11:0]          gain_value;
   logic [11:0]          offset_value;
   logic                 debug_run;
   logic [3:0]           irq_enable_mask;
   logic [3:0]           irq_flag_bits;
   logic [31:0]          rdata;
   logic                 rerr;
   logic [2:0]           es;
   int                   fail_count = 0;
   int                   total_checks = 0;

   always #50 pclk = ~pclk;

   adc_control_register_file #(.SYNC_CYCLES(SYNC)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .peripheral_access_controller(peripheral_access_controller),
      .result_done(result_done), .result_data(result_data), .window_hit(window_hit),
      .overrun_hit(overrun_hit), .keep_running_asleep(keep_running_asleep),
      .converter_enabled(converter_enabled),
      .ref_buffer_compensation(ref_buffer_compensation),
      .reference_choice(reference_choice), .reference_source(reference_source),
      .window_lower(window_lower), .window_upper(window_upper), .gain_value(gain_value),
      .offset_value(offset_value), .debug_run(debug_run),
      .irq_enable_mask(irq_enable_mask), .irq_flag_bits(irq_flag_bits));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Answer is taken at the rising edge that completes the access, before it updates
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                       input logic [3:0] s);
      int   n;
      logic rdy;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         rdy = pready;
         rdata = prdata;
         rerr = pslverr;
         n++;
      end while (rdy !== 1'b1 && n < 200);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
      if (n >= 200) check(32'h0, 32'h1, "no bus answer");
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
      xfer(1'b1, idx, d, s);
   endtask

   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp, input string what);
      xfer(1'b0, idx, 32'h0, 4'h0);
      check(rdata, exp, what);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         xfer(1'b0, IDX_STATUS, 32'h0, 4'h0);
         n++;
      end while (rdata[STATUS_BUSY_BIT] !== 1'b0 && n < 40);
      check(rdata, 32'h0, "busy stuck");
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(IDX_MAIN, 32'h0, "main reset");
      rchk(IDX_REF, 32'h0, "ref reset");
      rchk(IDX_RESULT, 32'h0, "result reset");
      rchk(IDX_LOWER, 32'h0, "lower reset");
      $display("Test reset values done");
      wr(IDX_LOWER, 32'hdead_a5c3, 4'hf);
      rchk(IDX_LOWER, 32'h0000_a5c3, "word write");
      wr(IDX_LOWER, 32'h0000_7700, 4'h2);
      rchk(IDX_LOWER, 32'h0000_77c3, "high lane");
      wr(IDX_LOWER, 32'h0000_ee11, 4'h1);
      check({16'h0, window_lower}, 32'h7711, "low lane keep");
      wr(IDX_UPPER, 32'h0000_005a, 4'h1);
      check({16'h0, window_upper}, 32'h5a, "low lane");
      $display("Test lanes done");
      wr(IDX_MAIN, 32'h4, 4'h1);
      check({31'h0, keep_running_asleep}, 32'h1, "standby run");
      wr(IDX_MAIN, 32'h6, 4'h1);
      rchk(IDX_MAIN, 32'h6, "enable readback");
      rchk(IDX_STATUS, 32'h80, "busy set");
      check({31'h0, converter_enabled}, 32'h0, "enable early");
      wait_idle();
      check({31'h0, converter_enabled}, 32'h1, "enabled");
      check({31'h0, irq_flag_bits[FLAG_SYNC_BIT]}, 32'h1, "sync flag");
      $display("Test enable done");
      wr(IDX_GAIN, 32'h0000_0123, 4'h3);
      rchk(IDX_GAIN, 32'h0, "gain while on");
      wr(IDX_MAIN, 32'h4, 4'h1);
      wait_idle();
      wr(IDX_GAIN, 32'h0000_fabc, 4'h3);
      rchk(IDX_GAIN, 32'h0000_0abc, "gain half");
      wr(IDX_GAIN, 32'h0000_0500, 4'h2);
      check({20'h0, gain_value}, 32'h5bc, "gain lane");
      $display("Test enable protection done");
      @(posedge pclk);
      peripheral_access_controller <= 1'b1;
      wr(IDX_REF, 32'h83, 4'h1);
      wr(IDX_DEBUG, 32'h1, 4'h1);
      rchk(IDX_REF, 32'h0, "ref protected");
      check({31'h0, debug_run}, 32'h0, "debug protected");
      @(posedge pclk);
      peripheral_access_controller <= 1'b0;
      for (int c = 0; c < 16; c++) begin
         wr(IDX_REF, {24'h0, c[0], 3'b000, c[3:0]}, 4'h1);
         es = (c <= 4) ? c[2:0] : ref_reserved;
         check({28'h0, reference_choice}, {28'h0, c[3:0]}, "ref code");
         check({31'h0, ref_buffer_compensation}, {31'h0, c[0]}, "ref comp");
         check({29'h0, reference_source}, {29'h0, es}, "ref source");
      end
      $display("Test reference done");
      wr(IDX_IENSET, 32'h5, 4'h1);
      wr(IDX_IENCLR, 32'h1, 4'h1);
      wr(IDX_IENCLR, 32'h0, 4'h1);
      rchk(IDX_IENSET, 32'h4, "irq enable");
      wr(IDX_FLAGS, 32'hf, 4'h1);
      @(posedge pclk);
      result_done <= 1'b1;
      window_hit <= 1'b1;
      overrun_hit <= 1'b1;
      result_data <= 16'h1234;
      @(posedge pclk);
      result_done <= 1'b0;
      window_hit <= 1'b0;
      overrun_hit <= 1'b0;
      rchk(IDX_FLAGS, 32'h7, "flags set");
      rchk(IDX_RESULT, 32'h1234, "result");
      wr(IDX_FLAGS, 32'h2, 4'h1);
      wr(IDX_FLAGS, 32'h0, 4'h1);
      check({28'h0, irq_flag_bits}, 32'h5, "flag clear");
      $display("Test flags done");
      wr(IDX_REF, 32'h83, 4'h1);
      wr(IDX_DEBUG, 32'h1, 4'h1);
      wr(IDX_MAIN, 32'h6, 4'h1);
      wait_idle();
      rchk(IDX_REF, 32'h83, "zero reset bit");
      wr(IDX_MAIN, 32'h1, 4'h1);
      rchk(IDX_MAIN, 32'h7, "reset wins");
      rchk(IDX_STATUS, 32'h80, "busy in reset");
      wait_idle();
      rchk(IDX_MAIN, 32'h0, "reset bit clear");
      rchk(IDX_REF, 32'h0, "ref cleared");
      rchk(IDX_GAIN, 32'h0, "gain cleared");
      rchk(IDX_LOWER, 32'h0, "lower cleared");
      rchk(IDX_FLAGS, 32'h8, "flags cleared");
      check({28'h0, irq_enable_mask}, 32'h0, "irq enable cleared");
      check({31'h0, converter_enabled}, 32'h0, "disabled");
      rchk(IDX_DEBUG, 32'h1, "debug kept");
      wr(IDX_OFFSET, 32'h0000_0a55, 4'h1);
      wr(IDX_OFFSET, 32'h0000_f300, 4'h2);
      check({20'h0, offset_value}, 32'h355, "offset lanes");
      $display("Test soft reset done");
      rchk(6'h3f, 32'h0, "unmapped data");
      check({31'h0, rerr}, 32'h1, "unmapped read error");
      wr(6'h3e, 32'hff, 4'hf);
      check({31'h0, rerr}, 32'h1, "unmapped write error");
      $display("Test unmapped done");
      test_done();
   end
endmodule // adc_control_register_file_test
